/* mission_alarm_defines.svh */
// Purpose: Offsets, fields, reset values and timing of the alarm logger
// Assumes: 8-bit register page reached through copy-scratchpad writes
// Notes: Definitions only
`ifndef MISSION_ALARM_DEFINES_SVH
`define MISSION_ALARM_DEFINES_SVH

// ------------------------------------------------------------
// Register page offsets
// ------------------------------------------------------------
`define ADDR_PAGE_LO 16'h0200
`define ADDR_WR_LAST 16'h0213
`define ADDR_LOW_LIMIT 16'h020b
`define ADDR_HIGH_LIMIT 16'h020c
`define ADDR_INTERVAL 16'h020d
`define ADDR_CONTROL 16'h020e
`define ADDR_DELAY_LO 16'h0212
`define ADDR_DELAY_HI 16'h0213
`define ADDR_STATUS 16'h0214
`define ADDR_STAMP_LO 16'h0215
`define ADDR_STAMP_HI 16'h0219
`define ADDR_COUNT_LO 16'h021a
`define ADDR_COUNT_HI 16'h021c
`define ADDR_COLD_LO 16'h0220
`define ADDR_HOT_LO 16'h0250
`define ADDR_HOT_HI 16'h027f

// ------------------------------------------------------------
// Control and status fields
// ------------------------------------------------------------
`define CTL_TIMER_SEARCH 0
`define CTL_HOT_SEARCH 1
`define CTL_COLD_SEARCH 2
`define CTL_WRAP 3
`define CTL_MISSION_N 4
`define CTL_ZERO 5
`define CTL_CLEAR_ARM 6
`define CTL_OSC_N 7
`define STS_TIMER 0
`define STS_HOT 1
`define STS_COLD 2
`define STS_SAMPLING 4
`define STS_MISSION 5
`define STS_BUSY_N 7

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define CONTROL_RESET 8'h00
`define BYTE_ZERO 8'h00
`define DUR_MAX 8'hff
`define DUR_FIRST 8'h01
`define ENTRY_BYTES 4
`define ENTRIES 12
`define REGION_BYTES 48
`define LOG_BYTES 12'd2048

// ------------------------------------------------------------
// Timing in milliseconds and kHz
// ------------------------------------------------------------
`define CLK_KHZ 200000
`define WAKE_MS 250
`define CONV_TOTAL_MS 750

`endif

/* mission_alarm_pkg.sv */
// Purpose: Types shared by the alarm logger control
// Assumes: Nothing
// Notes: Types only
package mission_alarm_pkg;

  // Self-initiated sample phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAKE,
    PH_CONVERT
  } phase_t;

  typedef logic [7:0] byte_t;

endpackage : mission_alarm_pkg

/* mission_alarm_logger_ctrl.sv */
// Purpose: Mission control, status and temperature alarm logging
// Assumes: Register writes arrive as copy-scratchpad byte writes; samples come from the converter
// Notes: Clocked by the logger's own clock; the serial engine and converter live outside
//
// Overview of operation
// - Sample at or past a limit alarms, stamps and counts duration.
// - Stamp copies sample counter, low byte at lowest address.
// - Byte above each stamp counts samples beyond that limit.
// - Duration saturated at 255 while still out opens a new entry.
// - Return inside band stops counting; next crossing opens new entry.
// - Cold entries fill a 48-byte region, twelve at most.
// - Hot entries fill their own 48-byte region, twelve at most.
// - First page write in a mission ends it, data unchanged.
// - Writes at 215h and above are ignored.
// - Control bits 0-2 enable search answer on timer, hot, cold alarms.
// - Control bit 3 wraps the log; clear stops logging when full.
// - Control bit 4 low lets interval write start mission; bit 5 reads 0.
// - Control bit 6 arms clear; next memory command drops it.
// - Control bit 7 low runs the oscillator.
// - Status bit 0 set by clock alarm, cleared by 0.
// - Status bits 1, 2 set by hot, cold samples, cleared by 0.
// - Status bit 4 high over wake and conversion; 250 ms wake, 750 ms max.
// - Status bit 5 rises on enabled nonzero interval write; falls at end.
// - Writing 0 to status bit 5 ends mission; bits 3, 4, 6, 7 read-only.
// - Status bit 6 shows memory cleared; start needs it and drops it.
// - Status bit 7 reads 0 during any conversion.
// - Mission sample counter is three register bytes.
// - Start copies clock to stamp, sets mission, drops cleared flag.
`timescale 1ns/1ps
`include "mission_alarm_defines.svh"

module mission_alarm_logger_ctrl #(
  parameter int unsigned WAKE_CYCLES = `WAKE_MS * `CLK_KHZ,
  parameter int unsigned CONV_CYCLES = (`CONV_TOTAL_MS - `WAKE_MS) * `CLK_KHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register page access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire mission_alarm_pkg::byte_t reg_wdata,
  output mission_alarm_pkg::byte_t reg_rdata,
  // Memory function commands
  input wire logic mem_cmd,
  input wire logic mem_cmd_is_clear,
  // Clock and converter events
  input wire logic rtc_alarm,
  input wire logic [39:0] rtc_now,
  input wire logic sample_due,
  input wire logic sample_done,
  input wire mission_alarm_pkg::byte_t sample_temp,
  input wire logic cmd_conv_busy,
  // Outputs to surrounding logic
  output logic conv_start,
  output logic log_store,
  output logic [10:0] log_addr,
  output logic search_match,
  output logic osc_run,
  output logic mission_active,
  output mission_alarm_pkg::byte_t sample_interval,
  output logic [15:0] start_delay
);
  import mission_alarm_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Byte index of an entry in the alarm regions
  function automatic int entry_base(input int side, input logic [3:0] idx);
    entry_base = side * `REGION_BYTES + int'(idx) * `ENTRY_BYTES;
  endfunction : entry_base

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  byte_t low_temp_limit;
  byte_t high_temp_limit;
  byte_t mission_control;
  logic timer_alarm_flag;
  logic hot_alarm_flag;
  logic cold_alarm_flag;
  logic sampling_active;
  logic memory_zeroed;
  logic conversion_busy_n;
  logic [39:0] mission_stamp;
  logic [23:0] sample_count;
  logic [11:0] log_count;
  byte_t alarm_mem [0:2*`REGION_BYTES-1];
  logic [3:0] entry_ptr [0:1];
  logic in_alarm [0:1];
  byte_t dur_now [0:1];
  phase_t phase;
  logic [31:0] phase_cnt;

  // ------------------------------------------------------------
  // Decoded events
  // ------------------------------------------------------------
  logic page_wr;
  logic kill_wr;
  logic cfg_wr;
  logic start_now;
  logic clear_now;
  logic took_sample;
  logic [23:0] next_count;
  logic out_band [0:1];

  assign page_wr = reg_wr && in_range(reg_addr, `ADDR_PAGE_LO, `ADDR_WR_LAST);
  assign kill_wr = page_wr && mission_active;
  assign cfg_wr = page_wr && !mission_active;
  assign start_now = cfg_wr && (reg_addr == `ADDR_INTERVAL) && (reg_wdata != `BYTE_ZERO)
                     && !mission_control[`CTL_MISSION_N] && memory_zeroed;
  assign clear_now = mem_cmd && mem_cmd_is_clear && mission_control[`CTL_CLEAR_ARM];
  assign took_sample = sample_done && mission_active && (phase == PH_CONVERT);
  assign next_count = sample_count + 24'd1;
  assign out_band[0] = sample_temp <= low_temp_limit;
  assign out_band[1] = sample_temp >= high_temp_limit;

  // ------------------------------------------------------------
  // Limits, interval, start delay
  // ------------------------------------------------------------
  // Writes during a mission only end it, so settings stay intact
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_temp_limit <= `BYTE_ZERO;
      high_temp_limit <= `BYTE_ZERO;
      sample_interval <= `BYTE_ZERO;
      start_delay <= 16'h0000;
    end else if (clear_now) begin
      sample_interval <= `BYTE_ZERO;
      start_delay <= 16'h0000;
    end else if (cfg_wr) begin
      unique case (reg_addr)
        `ADDR_LOW_LIMIT: low_temp_limit <= reg_wdata;
        `ADDR_HIGH_LIMIT: high_temp_limit <= reg_wdata;
        `ADDR_INTERVAL: sample_interval <= reg_wdata;
        `ADDR_DELAY_LO: start_delay[7:0] <= reg_wdata;
        `ADDR_DELAY_HI: start_delay[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Arm bit drops on any memory command, armed or not
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mission_control <= `CONTROL_RESET;
    end else if (cfg_wr && reg_addr == `ADDR_CONTROL) begin
      mission_control <= reg_wdata;
      mission_control[`CTL_ZERO] <= 1'b0;
    end else if (mem_cmd) begin
      mission_control[`CTL_CLEAR_ARM] <= 1'b0;
    end
  end

  // Oscillator runs while its enable reads 0
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_run <= 1'b1;
    end else begin
      osc_run <= !mission_control[`CTL_OSC_N];
    end
  end

  // ------------------------------------------------------------
  // Mission and memory-cleared flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mission_active <= 1'b0;
      memory_zeroed <= 1'b0;
    end else begin
      if (start_now) begin
        mission_active <= 1'b1;
        memory_zeroed <= 1'b0;
      end else if (kill_wr) begin
        mission_active <= 1'b0;
      end else if (reg_wr && reg_addr == `ADDR_STATUS && !reg_wdata[`STS_MISSION]) begin
        mission_active <= 1'b0;
      end
      if (clear_now && !mission_active) begin
        memory_zeroed <= 1'b1;
      end
    end
  end

  // Clock copy at start; cleared by the clear command
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mission_stamp <= 40'h0000000000;
    end else if (clear_now) begin
      mission_stamp <= 40'h0000000000;
    end else if (start_now) begin
      mission_stamp <= rtc_now;
    end
  end

  // ------------------------------------------------------------
  // Alarm flags; a set in the same cycle as a clear wins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer_alarm_flag <= 1'b0;
      hot_alarm_flag <= 1'b0;
      cold_alarm_flag <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_STATUS) begin
        if (!reg_wdata[`STS_TIMER]) timer_alarm_flag <= 1'b0;
        if (!reg_wdata[`STS_HOT]) hot_alarm_flag <= 1'b0;
        if (!reg_wdata[`STS_COLD]) cold_alarm_flag <= 1'b0;
      end
      if (rtc_alarm) timer_alarm_flag <= 1'b1;
      if (took_sample && out_band[1]) hot_alarm_flag <= 1'b1;
      if (took_sample && out_band[0]) cold_alarm_flag <= 1'b1;
    end
  end

  // Conditional search answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      search_match <= 1'b0;
    end else begin
      search_match <= (mission_control[`CTL_TIMER_SEARCH] && timer_alarm_flag)
                   || (mission_control[`CTL_HOT_SEARCH] && hot_alarm_flag)
                   || (mission_control[`CTL_COLD_SEARCH] && cold_alarm_flag);
    end
  end

  // ------------------------------------------------------------
  // Sample phase: wake-up, then conversion with a time limit
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= PH_IDLE;
      phase_cnt <= 32'd0;
      sampling_active <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      unique case (phase)
        PH_IDLE: begin
          if (sample_due && mission_active) begin
            phase <= PH_WAKE;
            phase_cnt <= 32'd1;
            sampling_active <= 1'b1;
          end
        end
        PH_WAKE: begin
          if (phase_cnt >= WAKE_CYCLES) begin
            phase <= PH_CONVERT;
            phase_cnt <= 32'd1;
            conv_start <= 1'b1;
          end else begin
            phase_cnt <= phase_cnt + 32'd1;
          end
        end
        PH_CONVERT: begin
          // Timeout guards against a converter that never answers
          if (sample_done || phase_cnt >= CONV_CYCLES) begin
            phase <= PH_IDLE;
            sampling_active <= 1'b0;
          end else begin
            phase_cnt <= phase_cnt + 32'd1;
          end
        end
      endcase
    end
  end

  // Busy low for self-initiated or commanded conversions
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conversion_busy_n <= 1'b1;
    end else begin
      conversion_busy_n <= !((phase != PH_IDLE) || cmd_conv_busy);
    end
  end

  // ------------------------------------------------------------
  // Sample counter and log addressing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sample_count <= 24'h000000;
    end else if (clear_now) begin
      sample_count <= 24'h000000;
    end else if (took_sample) begin
      sample_count <= next_count;
    end
  end

  // Log count saturates at capacity so a full log without wrap stays full
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      log_count <= 12'd0;
      log_store <= 1'b0;
      log_addr <= 11'd0;
    end else begin
      log_store <= 1'b0;
      if (clear_now) begin
        log_count <= 12'd0;
      end else if (took_sample) begin
        if (log_count < `LOG_BYTES) begin
          log_store <= 1'b1;
          log_addr <= log_count[10:0];
          log_count <= log_count + 12'd1;
        end else if (mission_control[`CTL_WRAP]) begin
          log_store <= 1'b1;
          log_addr <= 11'd0;
          log_count <= 12'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Alarm stamp and duration regions, side 0 cold, side 1 hot
  // ------------------------------------------------------------
  // Each entry: three stamp bytes then a duration byte
  always_ff @(posedge clk) begin
    if (!reset_n || clear_now) begin
      for (int i = 0; i < 2 * `REGION_BYTES; i++) begin
        alarm_mem[i] <= `BYTE_ZERO;
      end
      for (int s = 0; s < 2; s++) begin
        entry_ptr[s] <= 4'd0;
        in_alarm[s] <= 1'b0;
        dur_now[s] <= `BYTE_ZERO;
      end
    end else if (took_sample) begin
      for (int s = 0; s < 2; s++) begin
        if (!out_band[s]) begin
          in_alarm[s] <= 1'b0;
        end else if (!in_alarm[s] || dur_now[s] == `DUR_MAX) begin
          // New crossing or saturated counter opens a fresh entry
          if (entry_ptr[s] < 4'(`ENTRIES)) begin
            alarm_mem[entry_base(s, entry_ptr[s])] <= next_count[7:0];
            alarm_mem[entry_base(s, entry_ptr[s]) + 1] <= next_count[15:8];
            alarm_mem[entry_base(s, entry_ptr[s]) + 2] <= next_count[23:16];
            alarm_mem[entry_base(s, entry_ptr[s]) + 3] <= `DUR_FIRST;
            entry_ptr[s] <= entry_ptr[s] + 4'd1;
            in_alarm[s] <= 1'b1;
            dur_now[s] <= `DUR_FIRST;
          end else begin
            in_alarm[s] <= 1'b0;
          end
        end else begin
          alarm_mem[entry_base(s, entry_ptr[s] - 4'd1) + 3] <= dur_now[s] + 8'd1;
          dur_now[s] <= dur_now[s] + 8'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ------------------------------------------------------------
  // Nothing at 215h and up is writable; such writes fall through
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= `BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= `BYTE_ZERO;
      if (in_range(reg_addr, `ADDR_COLD_LO, `ADDR_HOT_HI)) begin
        reg_rdata <= alarm_mem[7'(reg_addr - `ADDR_COLD_LO)];
      end else if (in_range(reg_addr, `ADDR_STAMP_LO, `ADDR_STAMP_HI)) begin
        reg_rdata <= mission_stamp[8 * int'(reg_addr - `ADDR_STAMP_LO) +: 8];
      end else if (in_range(reg_addr, `ADDR_COUNT_LO, `ADDR_COUNT_HI)) begin
        reg_rdata <= sample_count[8 * int'(reg_addr - `ADDR_COUNT_LO) +: 8];
      end else begin
        unique case (reg_addr)
          `ADDR_LOW_LIMIT: reg_rdata <= low_temp_limit;
          `ADDR_HIGH_LIMIT: reg_rdata <= high_temp_limit;
          `ADDR_INTERVAL: reg_rdata <= sample_interval;
          `ADDR_CONTROL: reg_rdata <= mission_control;
          `ADDR_DELAY_LO: reg_rdata <= start_delay[7:0];
          `ADDR_DELAY_HI: reg_rdata <= start_delay[15:8];
          `ADDR_STATUS: reg_rdata <= {conversion_busy_n, memory_zeroed, mission_active,
                                      sampling_active, 1'b0, cold_alarm_flag,
                                      hot_alarm_flag, timer_alarm_flag};
          default: reg_rdata <= `BYTE_ZERO;
        endcase
      end
    end
  end

endmodule : mission_alarm_logger_ctrl

/* mission_alarm_logger_ctrl_properties.sv */
// Purpose: Port-level checks for the alarm logger control
// Assumes: Short wake phase
// Notes: Sees only top-level ports; attached with bind
`timescale 1ns/1ps
`include "mission_alarm_defines.svh"
module mission_alarm_logger_ctrl_checker #(
  parameter int unsigned WAKE_CYCLES = 8,
  parameter int unsigned CONV_CYCLES = 16
) (
  // Clock, reset and register access
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire mission_alarm_pkg::byte_t reg_wdata,
  input wire mission_alarm_pkg::byte_t reg_rdata,
  input wire logic mem_cmd,
  // Sample path and outputs
  input wire logic sample_due,
  input wire logic sample_done,
  input wire logic conv_start,
  input wire logic log_store,
  input wire logic osc_run,
  input wire logic mission_active,
  input wire mission_alarm_pkg::byte_t sample_interval,
  input wire logic [15:0] start_delay
);
  import mission_alarm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Cycles since sample request, saturating
  int unsigned since_due;
  always_ff @(posedge clk) begin
    if (!reset_n || sample_due) since_due <= 0;
    else if (since_due < 1000) since_due <= since_due + 1;
  end

  sequence s_page_wr_mission;
    mission_active && reg_wr && reg_addr >= `ADDR_PAGE_LO && reg_addr <= `ADDR_WR_LAST;
  endsequence
  sequence s_high_wr;
    reg_wr && reg_addr >= `ADDR_STAMP_LO && !mem_cmd;
  endsequence

  chk_start_cause: assert property (
    $rose(mission_active) |->
      $past(reg_wr && reg_addr == `ADDR_INTERVAL && reg_wdata != `BYTE_ZERO))
    else $error("mission began without an interval write");
  chk_page_wr_ends: assert property (s_page_wr_mission |=> !mission_active)
    else $error("page write did not end the mission");
  chk_page_wr_keeps: assert property (
    s_page_wr_mission |=> $stable(sample_interval) && $stable(start_delay))
    else $error("ending write altered register data");
  chk_high_wr_ignored: assert property (
    s_high_wr |=> $stable(mission_active) && $stable(sample_interval) && $stable(start_delay))
    else $error("write above the register page had an effect");
  chk_status_end: assert property (
    reg_wr && reg_addr == `ADDR_STATUS && !reg_wdata[`STS_MISSION] |=> !mission_active)
    else $error("status write of zero kept the mission");
  chk_ctrl_bit5_zero: assert property (
    reg_rd && reg_addr == `ADDR_CONTROL |=> !reg_rdata[`CTL_ZERO])
    else $error("control bit 5 read back as one");
  chk_osc_follow: assert property (
    reg_wr && reg_addr == `ADDR_CONTROL && !mission_active |=>
      ##2 (osc_run == !$past(reg_wdata[`CTL_OSC_N], 3)))
    else $error("oscillator does not follow control bit 7");
  chk_wake_length: assert property (
    conv_start |-> since_due + 2 >= WAKE_CYCLES && since_due <= WAKE_CYCLES + 1)
    else $error("conversion start off the wake length");
  chk_log_cause: assert property (log_store |-> $past(sample_done))
    else $error("log write without a finished sample");
endmodule : mission_alarm_logger_ctrl_checker

bind mission_alarm_logger_ctrl mission_alarm_logger_ctrl_checker #(
  .WAKE_CYCLES(WAKE_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd),
  .sample_due(sample_due), .sample_done(sample_done), .conv_start(conv_start),
  .log_store(log_store), .osc_run(osc_run), .mission_active(mission_active),
  .sample_interval(sample_interval), .start_delay(start_delay));

/* mission_alarm_bus_master.sv */
// Purpose: Master model issuing register writes, reads and memory commands
// Assumes: One request at a time, launched at the falling edge
// Notes: Released address and data show the inverse of their last value
`timescale 1ns/1ps
module mission_alarm_bus_master (
  // Clock and answer
  input wire logic clk,
  input wire mission_alarm_pkg::byte_t reg_rdata,
  // Requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output mission_alarm_pkg::byte_t reg_wdata,
  output logic mem_cmd,
  output logic mem_cmd_is_clear
);
  import mission_alarm_pkg::*;
  initial begin
    {reg_wr, reg_rd, mem_cmd, mem_cmd_is_clear} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [15:0] a, input byte_t d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask : wr

  task automatic rd(input logic [15:0] a, output byte_t d);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask : rd

  // Arm, then clear as the very next access
  task automatic clear_memory();
    wr(16'h020e, 8'h40);
    @(negedge clk);
    {mem_cmd, mem_cmd_is_clear} = 2'h3;
    @(negedge clk);
    {mem_cmd, mem_cmd_is_clear} = 2'h0;
  endtask : clear_memory
endmodule : mission_alarm_bus_master

/* mission_alarm_logger_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the alarm logger control
// Assumes: Short wake and conversion counts; limits 40h and 80h
// Notes: Converter and clock events here, registers via the master
`timescale 1ns/1ps
`include "mission_alarm_defines.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module mission_alarm_logger_ctrl_tb_top;
  import mission_alarm_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, rtc_alarm = 1'b0, sample_due = 1'b0;
  logic sample_done = 1'b0, cmd_conv_busy = 1'b0, reg_wr, reg_rd, mem_cmd, mem_cmd_is_clear;
  logic conv_start, log_store, search_match, osc_run, mission_active;
  logic [15:0] reg_addr, start_delay;
  logic [10:0] log_addr;
  logic [39:0] rtc_now = 40'h0504030201;
  byte_t reg_wdata, reg_rdata, sample_interval, sample_temp = 8'h00, v;
  logic [31:0] w;
  int mismatches = 0, checks = 0;
  always #2.5 clk = ~clk;

  mission_alarm_logger_ctrl #(.WAKE_CYCLES(8), .CONV_CYCLES(16)) i_dut (.clk(clk),
    .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd),
    .mem_cmd_is_clear(mem_cmd_is_clear), .rtc_alarm(rtc_alarm), .rtc_now(rtc_now),
    .sample_due(sample_due), .sample_done(sample_done), .sample_temp(sample_temp),
    .cmd_conv_busy(cmd_conv_busy), .conv_start(conv_start), .log_store(log_store),
    .log_addr(log_addr), .search_match(search_match), .osc_run(osc_run),
    .mission_active(mission_active), .sample_interval(sample_interval),
    .start_delay(start_delay));
  mission_alarm_bus_master u_master (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .mem_cmd(mem_cmd),
    .mem_cmd_is_clear(mem_cmd_is_clear));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic rd_chk(input logic [15:0] a, input byte_t e);
    u_master.rd(a, v);
    `CHECK(v, e)
  endtask : rd_chk
  // Entry bytes, lowest address lowest
  task automatic rd_entry(input logic [15:0] a, input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      u_master.rd(a + 16'(i), v);
      w[8*i +: 8] = v;
    end
    `CHECK(w, e)
  endtask : rd_entry
  task automatic pulse_alarm();
    @(negedge clk) rtc_alarm = 1'b1;
    @(negedge clk) rtc_alarm = 1'b0;
  endtask : pulse_alarm
  // One sample; status seen in wake and in conversion
  task automatic take_sample(input byte_t t);
    int n;
    n = 0;
    @(negedge clk) sample_due = 1'b1;
    @(negedge clk) sample_due = 1'b0;
    u_master.rd(`ADDR_STATUS, v);
    `CHECK(v[`STS_SAMPLING], 1'b1)
    while (conv_start !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      mismatches++;
      final_report();
    end
    u_master.rd(`ADDR_STATUS, v);
    `CHECK(v[`STS_BUSY_N], 1'b0)
    {sample_temp, sample_done} = {t, 1'b1};
    @(negedge clk) sample_done = 1'b0;
    `CHECK(log_store, 1'b1)
  endtask : take_sample
  task automatic start_mission();
    u_master.clear_memory();
    rd_chk(`ADDR_CONTROL, 8'h00);
    rd_chk(`ADDR_STATUS, 8'hc0);
    u_master.wr(`ADDR_INTERVAL, 8'h05);
    `CHECK(mission_active, 1'b1)
    rd_chk(`ADDR_STATUS, 8'ha0);
  endtask : start_mission

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic check_reset_control();
    `CHECK(osc_run, 1'b1)
    rd_chk(`ADDR_STATUS, 8'h80);
    u_master.wr(`ADDR_INTERVAL, 8'h05);
    `CHECK(mission_active, 1'b0)
    u_master.wr(`ADDR_CONTROL, 8'ha0);
    rd_chk(`ADDR_CONTROL, 8'h80);
    `CHECK(osc_run, 1'b0)
    u_master.wr(`ADDR_CONTROL, 8'h00);
    pulse_alarm();
    rd_chk(`ADDR_STATUS, 8'h81);
    u_master.wr(`ADDR_STATUS, 8'h00);
    rd_chk(`ADDR_STATUS, 8'h80);
    cmd_conv_busy = 1'b1;
    rd_chk(`ADDR_STATUS, 8'h00);
    cmd_conv_busy = 1'b0;
  endtask : check_reset_control
  // Limit edges, two cold crossings, a hot run past saturation
  task automatic check_alarms();
    u_master.wr(`ADDR_LOW_LIMIT, 8'h40);
    u_master.wr(`ADDR_HIGH_LIMIT, 8'h80);
    start_mission();
    for (int i = 0; i < 5; i++) rd_chk(`ADDR_STAMP_LO + 16'(i), rtc_now[8*i +: 8]);
    take_sample(8'h60);
    take_sample(8'h40);
    take_sample(8'h30);
    take_sample(8'h60);
    take_sample(8'h80);
    take_sample(8'h20);
    rd_chk(`ADDR_STATUS, 8'ha6);
    rd_entry(`ADDR_COLD_LO, 32'h02000002);
    rd_entry(`ADDR_HOT_LO, 32'h01000005);
    rd_entry(`ADDR_COLD_LO + 16'h0004, 32'h01000006);
    repeat (256) take_sample(8'hc0);
    rd_entry(`ADDR_HOT_LO + 16'h0004, 32'hff000007);
    rd_entry(`ADDR_HOT_LO + 16'h0008, 32'h01000106);
    rd_chk(`ADDR_COUNT_LO, 8'h06);
    rd_chk(`ADDR_COUNT_LO + 16'h0001, 8'h01);
  endtask : check_alarms
  task automatic check_search();
    u_master.wr(`ADDR_CONTROL, 8'h02);
    `CHECK(mission_active, 1'b0)
    rd_chk(`ADDR_CONTROL, 8'h00);
    u_master.wr(`ADDR_CONTROL, 8'h02);
    @(negedge clk);
    `CHECK(search_match, 1'b1)
    u_master.wr(`ADDR_STATUS, 8'h05);
    rd_chk(`ADDR_STATUS, 8'h84);
    `CHECK(search_match, 1'b0)
    u_master.wr(`ADDR_CONTROL, 8'h04);
    @(negedge clk);
    `CHECK(search_match, 1'b1)
    u_master.wr(`ADDR_CONTROL, 8'h01);
    @(negedge clk);
    `CHECK(search_match, 1'b0)
    pulse_alarm();
    @(negedge clk);
    `CHECK(search_match, 1'b1)
    u_master.wr(`ADDR_STATUS, 8'h00);
  endtask : check_search
  task automatic check_end();
    start_mission();
    u_master.wr(`ADDR_INTERVAL, 8'h09);
    `CHECK(mission_active, 1'b0)
    rd_chk(`ADDR_INTERVAL, 8'h05);
    u_master.wr(`ADDR_INTERVAL, 8'h09);
    rd_chk(`ADDR_INTERVAL, 8'h09);
    start_mission();
    u_master.wr(`ADDR_COUNT_LO, 8'hff);
    rd_chk(`ADDR_COUNT_LO, 8'h00);
    `CHECK(mission_active, 1'b1)
    u_master.wr(`ADDR_STATUS, 8'hd8);
    `CHECK(mission_active, 1'b0)
    rd_chk(`ADDR_STATUS, 8'h80);
  endtask : check_end

  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    check_reset_control();
    check_alarms();
    check_search();
    check_end();
    final_report();
  end
endmodule : mission_alarm_logger_ctrl_tb_top
